/* verilog/cmpdc_pkg.sv */
// Package of the comparator digital control block: offsets, fields, resets, types.
// Assumes a byte-wide register port with read data one cycle after the read strobe.
package cmpdc_pkg;

	// Register offsets
	localparam logic [1:0] OFF_CTRL0 = 2'h0;
	localparam logic [1:0] OFF_CTRL1 = 2'h1;
	localparam logic [1:0] OFF_OUT   = 2'h2;

	// Control register 0 fields
	localparam int C0_ENABLE = 7;
	localparam int C0_RESULT = 6;
	localparam int C0_OE     = 5;
	localparam int C0_POL    = 4;
	localparam int C0_SPEED  = 2;
	localparam int C0_HYS    = 1;
	localparam int C0_SYNC   = 0;

	// Control register 1 fields
	localparam int C1_RISE   = 7;
	localparam int C1_FALL   = 6;
	localparam int C1_PSEL_H = 5;
	localparam int C1_PSEL_L = 4;
	localparam int C1_NSEL   = 0;

	// Mirror register field
	localparam int OUT_MIRROR = 0;

	// Reset values
	localparam logic       SPEED_RST = 1'h1;
	localparam logic [7:0] DATA_RST  = 8'h00;

	// Positive input selections
	typedef enum logic [1:0] {
		CMPDC_PSEL_PIN = 2'h0,
		CMPDC_PSEL_DAC = 2'h1,
		CMPDC_PSEL_FVR = 2'h2,
		CMPDC_PSEL_GND = 2'h3
	} cmpdc_psel_e;

	// Software-visible configuration
	typedef struct packed {
		logic        enable;
		logic        pin_oe;
		logic        polarity;
		logic        speed;
		logic        hysteresis;
		logic        sync;
		logic        rise_en;
		logic        fall_en;
		cmpdc_psel_e psel;
		logic        nsel;
	} cmpdc_cfg_s;

	// Controls going to the analog core
	typedef struct packed {
		logic        enable;
		logic        speed;
		logic        hysteresis;
		logic        pos_pin;
		logic        pos_dac;
		logic        pos_fvr;
		logic        pos_gnd;
		logic        neg_pin0;
		logic        neg_pin1;
	} cmpdc_analog_s;

	// Register port request
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cmpdc_bus_s;

endpackage : cmpdc_pkg

/* verilog/cmpdc_sync_cap.sv */
// Capture stage of the comparator result toward the timer gate and the pin.
// Assumes the timer source clock, after its prescaler, arrives synchronous to clk_i.
`timescale 1ns/1ns
module cmpdc_sync_cap (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	// Inputs
	input  wire logic res_i,
	input  wire logic sync_en_i,
	input  wire logic tmr_clk_i,
	// Output
	output logic      res_o
);

	typedef struct packed {
		logic tclk_prev;
		logic held;
	} cmpdc_cap_s;

	cmpdc_cap_s st_q;
	cmpdc_cap_s st_d;

	always_comb begin
		st_d           = st_q;
		st_d.tclk_prev = tmr_clk_i;
		if (st_q.tclk_prev && !tmr_clk_i) begin
			st_d.held = res_i; // [RQ10]
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Unsynchronised path passes straight through
	assign res_o = sync_en_i ? st_q.held : res_i; // [RQ24]

endmodule : cmpdc_sync_cap

/* verilog/cmpdc_top.sv */
// Digital control around one analog comparator: registers, polarity, pin override,
// edge flag, input selection and the result toward the timer gate and PWM shutdown.
// Assumes a raw comparator output synchronous to clk_i and an outside interrupt controller.
`timescale 1ns/1ns
// Functional notes
// [RQ1] Result readable in control and mirror registers
// [RQ2] Pin driven only with oe, output direction, enable
// [RQ3] Output enable overrides port latch, regardless enable
// [RQ4] Internal result registered each cycle
// [RQ5] Polarity bit inverts the result
// [RQ6] Result one when positive exceeds negative, polarity zero
// [RQ7] Speed bit resets to one, freely writable
// [RQ8] Hysteresis follows its enable bit
// [RQ9] Result offered as timer gate source
// [RQ10] Sync captures on timer clock falling edge
// [RQ11] Software should sync when gating the timer
// [RQ12] Enabled rising or falling edges set flag
// [RQ13] Software configures enables for interrupts
// [RQ14] Flag cleared only by write; edge wins
// [RQ15] Edges detected after polarity and enable gating
// [RQ16] Two-bit field selects one of four positives
// [RQ17] Inputs disconnected while comparator disabled
// [RQ18] One bit selects one of two negatives
// [RQ19] Software sets analog select and input direction
// [RQ20] Result offered to PWM auto-shutdown
// [RQ21] Software verifies result after initialisation
// [RQ22] Positive select codes pin, DAC, reference
// [RQ23] Negative select zero first pin, one second
// [RQ24] Without sync output passes unsynchronised
// [RQ25] Mirror equals result bit, both read-only
module cmpdc_top (
	// Clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   sys_rst_i,
	// Register port
	input  wire logic [1:0]             reg_addr_i,
	input  wire logic [7:0]             reg_wdata_i,
	input  wire logic                   reg_wr_i,
	input  wire logic                   reg_rd_i,
	output logic      [7:0]             reg_rdata_o,
	// Interrupt flag register access
	input  wire logic                   irq_flag_wr_i,
	input  wire logic                   irq_flag_wdata_i,
	output logic                        cmp_irq_flag_o,
	// Analog core
	input  wire logic                   cmp_raw_i,
	output cmpdc_pkg::cmpdc_analog_s    analog_o,
	// Pin
	input  wire logic                   pin_direction_bit_i,
	input  wire logic                   port_latch_i,
	output logic                        pin_o,
	output logic                        pin_oe_o,
	// Timer and PWM
	input  wire logic                   tmr_clk_i,
	output logic                        tmr_gate_o,
	output logic                        pwm_shutdown_o
);

	typedef struct packed {
		cmpdc_pkg::cmpdc_cfg_s cfg;
		logic                  result;
		logic                  result_prev;
		logic                  flag;
		logic [7:0]            rdata;
	} cmpdc_state_s;

	cmpdc_state_s st_q;
	cmpdc_state_s st_d;
	cmpdc_pkg::cmpdc_bus_s bus;
	logic gated;
	logic ext_res;
	logic rise_ev;
	logic fall_ev;
	logic [7:0] ctrl0_val;
	logic [7:0] ctrl1_val;
	logic [7:0] out_val;

	assign bus.addr  = reg_addr_i;
	assign bus.wdata = reg_wdata_i;
	assign bus.wr    = reg_wr_i;
	assign bus.rd    = reg_rd_i;

	// Enable gating then polarity; raw is high when positive exceeds negative
	assign gated = (cmp_raw_i & st_q.cfg.enable) ^ st_q.cfg.polarity; // [RQ5] [RQ6]

	// Edges on the registered, polarity-applied result
	assign rise_ev = st_q.result & ~st_q.result_prev & st_q.cfg.rise_en; // [RQ12] [RQ15]
	assign fall_ev = ~st_q.result & st_q.result_prev & st_q.cfg.fall_en; // [RQ12] [RQ15]

	always_comb begin
		ctrl0_val                        = 8'h00;
		ctrl0_val[cmpdc_pkg::C0_ENABLE]  = st_q.cfg.enable;
		ctrl0_val[cmpdc_pkg::C0_RESULT]  = st_q.result; // [RQ1]
		ctrl0_val[cmpdc_pkg::C0_OE]      = st_q.cfg.pin_oe;
		ctrl0_val[cmpdc_pkg::C0_POL]     = st_q.cfg.polarity;
		ctrl0_val[cmpdc_pkg::C0_SPEED]   = st_q.cfg.speed;
		ctrl0_val[cmpdc_pkg::C0_HYS]     = st_q.cfg.hysteresis;
		ctrl0_val[cmpdc_pkg::C0_SYNC]    = st_q.cfg.sync;
		ctrl1_val                        = 8'h00;
		ctrl1_val[cmpdc_pkg::C1_RISE]    = st_q.cfg.rise_en;
		ctrl1_val[cmpdc_pkg::C1_FALL]    = st_q.cfg.fall_en;
		ctrl1_val[cmpdc_pkg::C1_PSEL_H:cmpdc_pkg::C1_PSEL_L] = st_q.cfg.psel;
		ctrl1_val[cmpdc_pkg::C1_NSEL]    = st_q.cfg.nsel;
		out_val                          = 8'h00;
		out_val[cmpdc_pkg::OUT_MIRROR]   = st_q.result; // [RQ1] [RQ25]
	end

	always_comb begin
		st_d             = st_q;
		st_d.result      = gated; // [RQ4]
		st_d.result_prev = st_q.result;
		st_d.rdata       = cmpdc_pkg::DATA_RST;
		if (bus.wr) begin
			unique case (bus.addr)
				cmpdc_pkg::OFF_CTRL0: begin
					st_d.cfg.enable     = bus.wdata[cmpdc_pkg::C0_ENABLE];
					st_d.cfg.pin_oe     = bus.wdata[cmpdc_pkg::C0_OE];
					st_d.cfg.polarity   = bus.wdata[cmpdc_pkg::C0_POL];
					st_d.cfg.speed      = bus.wdata[cmpdc_pkg::C0_SPEED]; // [RQ7]
					st_d.cfg.hysteresis = bus.wdata[cmpdc_pkg::C0_HYS];
					st_d.cfg.sync       = bus.wdata[cmpdc_pkg::C0_SYNC];
				end
				cmpdc_pkg::OFF_CTRL1: begin
					st_d.cfg.rise_en = bus.wdata[cmpdc_pkg::C1_RISE];
					st_d.cfg.fall_en = bus.wdata[cmpdc_pkg::C1_FALL];
					st_d.cfg.psel    = cmpdc_pkg::cmpdc_psel_e'(
						bus.wdata[cmpdc_pkg::C1_PSEL_H:cmpdc_pkg::C1_PSEL_L]);
					st_d.cfg.nsel    = bus.wdata[cmpdc_pkg::C1_NSEL];
				end
				default: begin
					// Mirror register and unmapped offsets ignore writes
				end
			endcase
		end
		if (bus.rd) begin
			unique case (bus.addr)
				cmpdc_pkg::OFF_CTRL0: st_d.rdata = ctrl0_val;
				cmpdc_pkg::OFF_CTRL1: st_d.rdata = ctrl1_val;
				cmpdc_pkg::OFF_OUT:   st_d.rdata = out_val;
				default:              st_d.rdata = cmpdc_pkg::DATA_RST;
			endcase
		end
		// Software write loads the flag, but an edge in the same cycle wins
		if (irq_flag_wr_i) begin
			st_d.flag = irq_flag_wdata_i; // [RQ14]
		end
		if (rise_ev || fall_ev) begin
			st_d.flag = 1'b1; // [RQ12] [RQ14]
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_q           <= '0;
			st_q.cfg.speed <= cmpdc_pkg::SPEED_RST; // [RQ7]
		end else begin
			st_q <= st_d;
		end
	end

	cmpdc_sync_cap u_sync_cap (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.res_i     (st_q.result),
		.sync_en_i (st_q.cfg.sync),
		.tmr_clk_i (tmr_clk_i),
		.res_o     (ext_res)
	);

	assign reg_rdata_o    = st_q.rdata;
	assign cmp_irq_flag_o = st_q.flag;
	assign tmr_gate_o     = ext_res; // [RQ9]
	assign pwm_shutdown_o = st_q.result; // [RQ20]

	// Override applies on oe alone; driver needs output direction and enable too
	assign pin_o    = st_q.cfg.pin_oe ? ext_res : port_latch_i; // [RQ3]
	assign pin_oe_o = st_q.cfg.pin_oe & ~pin_direction_bit_i & st_q.cfg.enable; // [RQ2]

	// Analog input routing, all disconnected while disabled
	always_comb begin
		analog_o            = '0;
		analog_o.enable     = st_q.cfg.enable;
		analog_o.speed      = st_q.cfg.speed;
		analog_o.hysteresis = st_q.cfg.hysteresis; // [RQ8]
		if (st_q.cfg.enable) begin // [RQ17]
			unique case (st_q.cfg.psel) // [RQ16] [RQ22]
				cmpdc_pkg::CMPDC_PSEL_PIN: analog_o.pos_pin = 1'b1;
				cmpdc_pkg::CMPDC_PSEL_DAC: analog_o.pos_dac = 1'b1;
				cmpdc_pkg::CMPDC_PSEL_FVR: analog_o.pos_fvr = 1'b1;
				cmpdc_pkg::CMPDC_PSEL_GND: analog_o.pos_gnd = 1'b1;
			endcase
			analog_o.neg_pin0 = ~st_q.cfg.nsel; // [RQ18] [RQ23]
			analog_o.neg_pin1 = st_q.cfg.nsel; // [RQ18] [RQ23]
		end
	end

endmodule : cmpdc_top

/* bench/cmpdc_analog_model.sv */
// Behavioural analog core: bench-set levels, routed by the select lines of the block.
// Assumes its output is resampled on clk_i before it reaches the block.
`timescale 1ns/1ns
module cmpdc_analog_model (
	// Clock
	input  wire logic                     clk_i,
	// Levels and routing
	input  wire logic [11:0]              pos_lvl_i,
	input  wire logic [7:0]               neg_lvl_i,
	input  wire cmpdc_pkg::cmpdc_analog_s analog_i,
	// Raw result
	output logic                          raw_o
);
	logic [3:0] vp;
	logic [3:0] vn;
	assign vp = analog_i.pos_pin ? pos_lvl_i[3:0] : analog_i.pos_dac ? pos_lvl_i[7:4] :
		analog_i.pos_fvr ? pos_lvl_i[11:8] : 4'h0;
	assign vn = analog_i.neg_pin1 ? neg_lvl_i[7:4] : neg_lvl_i[3:0];
	logic raw_q = 1'b0;
	// Disconnected inputs leave the output wandering
	always @(posedge clk_i) begin
		if (analog_i.enable)
			raw_q <= vp > vn;
		else
			raw_q <= ~raw_q;
	end
	assign raw_o = raw_q;
endmodule : cmpdc_analog_model

/* bench/cmpdc_monitor.sv */
// Checker of the comparator control block, bound to its top module.
// Assumes the shutdown output carries the registered result.
`timescale 1ns/1ns
module cmpdc_monitor (
	// Clock and reset
	input wire logic                     clk_i,
	input wire logic                     sys_rst_i,
	// Watched ports
	input wire logic [1:0]               reg_addr_i,
	input wire logic                     reg_rd_i,
	input wire logic [7:0]               reg_rdata_o,
	input wire logic                     irq_flag_wr_i,
	input wire logic                     irq_flag_wdata_i,
	input wire logic                     cmp_irq_flag_o,
	input wire cmpdc_pkg::cmpdc_analog_s analog_o,
	input wire logic                     pin_direction_bit_i,
	input wire logic                     pin_oe_o,
	input wire logic                     pwm_shutdown_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_rd_res;
		reg_rd_i && reg_addr_i inside {2'h0, 2'h2};
	endsequence
	sequence s_clr_quiet;
		irq_flag_wr_i && !irq_flag_wdata_i ##0 $stable(pwm_shutdown_o);
	endsequence
	property p_rd_res;
		s_rd_res |=> reg_rdata_o[$past(reg_addr_i) == 2'h0 ? 6 : 0] == $past(pwm_shutdown_o);
	endproperty
	a_rd_res: assert property (p_rd_res) else $error("result read mismatch");
	property p_oe;
		pin_oe_o |-> analog_o.enable && !pin_direction_bit_i;
	endproperty
	a_oe: assert property (p_oe) else $error("pin driven while not allowed");
	property p_off;
		!analog_o.enable |-> analog_o[5:0] == 6'h00;
	endproperty
	a_off: assert property (p_off) else $error("inputs routed while disabled");
	property p_pos;
		analog_o.enable |-> $onehot(analog_o[5:2]) && (analog_o.neg_pin0 != analog_o.neg_pin1);
	endproperty
	a_pos: assert property (p_pos) else $error("input routing not one-hot");
	property p_rise;
		$rose(cmp_irq_flag_o) |-> $past(pwm_shutdown_o) != $past(pwm_shutdown_o, 2) ||
			$past(irq_flag_wr_i && irq_flag_wdata_i);
	endproperty
	a_rise: assert property (p_rise) else $error("flag set without edge");
	property p_fall;
		$fell(cmp_irq_flag_o) |-> $past(irq_flag_wr_i) && !$past(irq_flag_wdata_i);
	endproperty
	a_fall: assert property (p_fall) else $error("flag cleared without write");
	property p_clr;
		s_clr_quiet |=> !cmp_irq_flag_o;
	endproperty
	a_clr: assert property (p_clr) else $error("flag not cleared by write");
	property p_speed;
		$fell(sys_rst_i) |-> analog_o.speed;
	endproperty
	a_speed: assert property (p_speed) else $error("speed not set after reset");
endmodule : cmpdc_monitor
bind cmpdc_top cmpdc_monitor cmpdc_monitor_i (.clk_i, .sys_rst_i, .reg_addr_i, .reg_rd_i,
	.reg_rdata_o, .irq_flag_wr_i, .irq_flag_wdata_i, .cmp_irq_flag_o, .analog_o,
	.pin_direction_bit_i, .pin_oe_o, .pwm_shutdown_o);

/* bench/test_cmpdc_top.sv */
// Testbench of the comparator control block with an analog core model.
// Assumes the model and checker are compiled before it.
`timescale 1ns/1ns
`define CK(n, e, a) begin total_checks++; if ((a) !== (e)) begin err_total++; \
	$display("ERROR %s exp %0h got %0h", n, e, a); end end
module test_cmpdc_top;
	logic        clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, irq_flag_wr_i = 0;
	logic        irq_flag_wdata_i = 0, pin_direction_bit_i = 1, port_latch_i = 1, tmr_clk_i = 1;
	logic        cmp_raw_i, cmp_irq_flag_o, pin_o, pin_oe_o, tmr_gate_o, pwm_shutdown_o;
	logic [1:0]  reg_addr_i = 0;
	logic [7:0]  reg_wdata_i = 0, reg_rdata_o, neg_lvl_i = 8'h88;
	logic [11:0] pos_lvl_i = 0;
	int          err_total = 0, total_checks = 0, cyc = 0;
	cmpdc_pkg::cmpdc_analog_s analog_o;
	cmpdc_top cmpdc_top_i (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .irq_flag_wr_i, .irq_flag_wdata_i, .cmp_irq_flag_o, .cmp_raw_i, .analog_o,
		.pin_direction_bit_i, .port_latch_i, .pin_o, .pin_oe_o, .tmr_clk_i, .tmr_gate_o,
		.pwm_shutdown_o);
	cmpdc_analog_model cmpdc_analog_model_i (.clk_i, .pos_lvl_i, .neg_lvl_i,
		.analog_i(analog_o), .raw_o(cmp_raw_i));
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) if (++cyc == 3000) begin
		err_total++;
		end_of_test;
	end
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_i) {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
		@(posedge clk_i) reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rc(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk_i) {reg_addr_i, reg_rd_i} <= {a, 1'b1};
		@(posedge clk_i) reg_rd_i <= 1'b0;
		@(negedge clk_i) `CK("rdata", e, reg_rdata_o)
	endtask : rc
	task automatic fl(input logic v);
		@(posedge clk_i) {irq_flag_wr_i, irq_flag_wdata_i} <= {1'b1, v};
		@(posedge clk_i) irq_flag_wr_i <= 1'b0;
	endtask : fl
	task automatic lv(input logic [11:0] p);
		@(posedge clk_i) pos_lvl_i <= p;
	endtask : lv
	task automatic t_reset;
		rc(2'h0, 8'h04);
		rc(2'h1, 8'h00);
		wr(2'h2, 8'hFF);
		wr(2'h0, 8'h48);
		rc(2'h2, 8'h00);
		rc(2'h3, 8'h00);
		rc(2'h0, 8'h00);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_pol;
		for (int i = 0; i < 4; i++) begin
			lv(i[0] ? 12'hFFF : 12'h000);
			wr(2'h0, {3'b100, i[1], 4'h4});
			repeat (3) @(negedge clk_i);
			rc(2'h0, {1'b1, i[0] ^ i[1], 1'b0, i[1], 4'h4});
			rc(2'h2, {7'h00, i[0] ^ i[1]});
			`CK("shutdown", i[0] ^ i[1], pwm_shutdown_o)
			`CK("gate", i[0] ^ i[1], tmr_gate_o)
		end
		$display("t_pol done");
	endtask : t_pol
	task automatic t_pin;
		lv(12'hFFF);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i) {pin_direction_bit_i, port_latch_i} <= {i[1], ~i[2]};
			wr(2'h0, {i[2], 1'b0, i[0], 5'h04});
			repeat (3) @(negedge clk_i);
			`CK("pin", i[0] ? i[2] : ~i[2], pin_o)
			`CK("pin_oe", i[0] & ~i[1] & i[2], pin_oe_o)
		end
		@(posedge clk_i) pin_direction_bit_i <= 1'b1;
		$display("t_pin done");
	endtask : t_pin
	task automatic t_irq;
		lv(12'h000);
		wr(2'h1, 8'h80);
		wr(2'h0, 8'h84);
		fl(1'b0);
		lv(12'hFFF);
		repeat (5) @(negedge clk_i);
		`CK("rise", 1'b1, cmp_irq_flag_o)
		fl(1'b0);
		lv(12'h000);
		repeat (5) @(negedge clk_i);
		`CK("no_fall", 1'b0, cmp_irq_flag_o)
		lv(12'hFFF);
		@(posedge clk_i);
		fl(1'b0);
		@(negedge clk_i) `CK("edge_wins", 1'b1, cmp_irq_flag_o)
		wr(2'h0, 8'h04);
		fl(1'b0);
		wr(2'h0, 8'h14);
		repeat (3) @(negedge clk_i);
		`CK("pol_edge", 1'b1, cmp_irq_flag_o)
		wr(2'h1, 8'h40);
		fl(1'b0);
		@(negedge clk_i) `CK("sw_clr", 1'b0, cmp_irq_flag_o)
		fl(1'b1);
		@(negedge clk_i) `CK("sw_set", 1'b1, cmp_irq_flag_o)
		fl(1'b0);
		wr(2'h0, 8'h04);
		repeat (3) @(negedge clk_i);
		`CK("fall", 1'b1, cmp_irq_flag_o)
		$display("t_irq done");
	endtask : t_irq
	task automatic t_sel;
		wr(2'h0, 8'h82);
		for (int i = 0; i < 8; i++) begin
			wr(2'h1, {2'b00, i[2:1], 3'h0, i[0]});
			rc(2'h1, {2'b00, i[2:1], 3'h0, i[0]});
			`CK("analog", {3'b101, 4'h8 >> i[2:1], ~i[0], i[0]}, analog_o)
		end
		wr(2'h0, 8'h00);
		@(negedge clk_i) `CK("analog_off", 9'h000, analog_o)
		$display("t_sel done");
	endtask : t_sel
	task automatic t_sync;
		wr(2'h1, 8'h00);
		wr(2'h0, 8'hA5);
		repeat (4) @(negedge clk_i);
		`CK("gate_hold", 1'b0, tmr_gate_o)
		`CK("pin_hold", 1'b0, pin_o)
		@(posedge clk_i) tmr_clk_i <= 1'b0;
		repeat (3) @(negedge clk_i);
		`CK("gate_cap", 1'b1, tmr_gate_o)
		`CK("pin_cap", 1'b1, pin_o)
		@(posedge clk_i) tmr_clk_i <= 1'b1;
		wr(2'h0, 8'hA4);
		lv(12'h000);
		repeat (3) @(negedge clk_i);
		`CK("gate_direct", 1'b0, tmr_gate_o)
		$display("t_sync done");
	endtask : t_sync
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_reset;
		t_pol;
		t_pin;
		t_irq;
		t_sel;
		t_sync;
		end_of_test;
	end
endmodule : test_cmpdc_top
